// *** rtl/iep_bank.sv ***
`timescale 1ns/1ns
// How it works
// - Enable bit one passes request, zero blocks
// - Enable bits read zero after reset
// - Unimplemented bits read zero, ignore writes
// - Field 111 means level seven, highest
// - Fields 001 to 111 map levels 1-7
// - Field 000 switches the source off
// - Priority fields reset to binary 100
// - First enable register source bit layout
// - Second enable register source bit layout
// - Third enable register source bit layout
// - Fourth enable register source bit layout
// - First priority register field layout
// - Second priority register field layout
// - Third priority register field layout
// - Source flag one means request raised
module iep_bank import iep_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  output logic [1:0] avs_response,
  input wire logic [N_EN_SLOT-1:0] flag_en_src,
  input wire logic [3*N_EN_SLOT-1:0] prio_ext,
  input wire logic [N_PR_SRC-1:0] flag_pr_src,
  input wire logic [N_PR_SRC-1:0] en_ext,
  output logic cpu_req,
  output logic [2:0] cpu_level,
  output logic [SRC_W-1:0] cpu_src,
  output logic irq
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    iep_bus_e bus; // Bus phase
    logic [3:0][15:0] en; // Enable registers
    logic [2:0][15:0] pr; // Priority registers
    logic [15:0] rdata; // Read data held for the answer
    logic [1:0] resp; // Answer code held for the answer
    logic req; // Request to the core
    logic [2:0] lvl; // Level of that request
    logic [SRC_W-1:0] src; // Source of that request
    logic [EVT_W-1:0] ist; // Sticky event status
    logic [EVT_W-1:0] ien; // Event interrupt enable
    logic irq; // Interrupt line
    logic wr_seen; // Any register write since reset
  } iep_state_s;

  localparam iep_state_s RST_S = '{
    bus: IEP_IDLE,
    en: EN_RST,
    pr: PR_RST,
    default: '0
  };

  iep_state_s s_q; // Current state
  iep_state_s s_d; // Next state

  iep_cand_if #(.N(N_CAND)) cif (); // Candidates to the arbiter

  logic acc; // Bus request present
  logic hit; // Address is mapped
  logic [15:0] rd; // Read mux
  logic [15:0] wd; // Write data, low half
  logic [1:0] be; // Byte enables of the low half
  logic take_wr; // Write takes effect this edge
  logic [EVT_W-1:0] evt; // Events this cycle
  logic [EVT_W-1:0] clr; // Clears this cycle
  logic [47:0] pr_flat; // Priority registers end to end
  logic any7; // A level-seven candidate exists
  logic [2:0] top_lvl; // Highest candidate level, found apart from the arbiter

  // ----------------------------------------------------------------
  // Arbiter
  // ----------------------------------------------------------------
  iep_arb #(.N(N_CAND)) u_arb (
    .c(cif)
  );

  // ----------------------------------------------------------------
  // Candidates
  // ----------------------------------------------------------------
  // Enable-covered slots take their level from outside; the rest take
  // their enable from outside and their level from the fields here
  always_comb begin
    pr_flat = s_q.pr;
    any7 = 1'b0;
    top_lvl = PRIO_OFF;
    for (int i = 0; i < N_EN_SLOT; i++) begin
      // Unimplemented enable bits are always zero, so their slots stay idle
      cif.valid[i] = flag_en_src[i] & s_q.en[i / 16][i % 16]
                     & (prio_ext[3 * i +: 3] != PRIO_OFF);
      cif.level[i] = prio_ext[3 * i +: 3];
    end
    for (int j = 0; j < N_PR_SRC; j++) begin
      // Field order: timer1, compare1, capture1, ext_irq0
      // timer2, compare2, capture2
      // uart1 rx, spi1 event, spi1 fault, timer3
      cif.valid[N_EN_SLOT + j] = flag_pr_src[j] & en_ext[j]
                                 & (pr_flat[iep_prio_lsb(j) +: 3] != PRIO_OFF);
      cif.level[N_EN_SLOT + j] = pr_flat[iep_prio_lsb(j) +: 3];
    end
    for (int k = 0; k < N_CAND; k++) begin
      if (cif.valid[k] && (cif.level[k] == PRIO_MAX)) begin
        any7 = 1'b1;
      end
      // Plain maximum, kept separate so the checks can judge the arbiter
      if (cif.valid[k] && (cif.level[k] > top_lvl)) begin
        top_lvl = cif.level[k];
      end
    end
  end

  // ----------------------------------------------------------------
  // Read decode
  // ----------------------------------------------------------------
  // Decoded from the address while the request stands
  always_comb begin
    hit = 1'b1;
    rd = '0;
    for (int k = 0; k < N_EN_REG; k++) begin
      if (iep_sel(avs_address, OFS_EN_BASE, k)) begin
        rd = s_q.en[k];
      end
    end
    for (int k = 0; k < N_PR_REG; k++) begin
      if (iep_sel(avs_address, OFS_PR_BASE, k)) begin
        rd = s_q.pr[k];
      end
    end
    if (avs_address == OFS_IST) begin
      rd = 16'(s_q.ist);
    end else if (avs_address == OFS_IEN) begin
      rd = 16'(s_q.ien);
    end else if (avs_address == OFS_CUR) begin
      rd = {5'h00, s_q.req, s_q.lvl, s_q.src};
    end else if (avs_address == OFS_ICLR) begin
      rd = '0; // Clear register reads as zero
    end else if (avs_address >= OFS_IST || avs_address[1:0] != 2'h0) begin
      hit = 1'b0; // Beyond the map or not word aligned
    end
  end

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    acc = avs_read | avs_write;
    wd = avs_writedata[15:0];
    be = avs_byteenable[1:0];
    take_wr = 1'b0;
    evt = '0;
    clr = '0;

    // Bus phase: one wait cycle, then the answer
    unique case (s_q.bus)
      IEP_IDLE: begin
        if (acc) begin
          s_d.bus = IEP_ACK;
          s_d.rdata = avs_read ? rd : 16'h0000;
          s_d.resp = hit ? RESP_OKAY : RESP_SLVERR;
          evt[EVT_BUS_ERR] = ~hit;
        end
      end
      IEP_ACK: begin
        s_d.bus = IEP_IDLE;
        take_wr = avs_write & hit;
      end
    endcase

    // Writes land at the edge where waitrequest is low
    if (take_wr) begin
      s_d.wr_seen = 1'b1;
      for (int k = 0; k < N_EN_REG; k++) begin
        if (iep_sel(avs_address, OFS_EN_BASE, k)) begin
          // Masks fix the bit layout of each register
          s_d.en[k] = iep_merge(s_q.en[k], wd, be, EN_MASK[k]);
        end
      end
      for (int k = 0; k < N_PR_REG; k++) begin
        if (iep_sel(avs_address, OFS_PR_BASE, k)) begin
          s_d.pr[k] = iep_merge(s_q.pr[k], wd, be, PR_MASK[k]);
        end
      end
      if (avs_address == OFS_ICLR && be[0]) begin
        clr = wd[EVT_W-1:0];
      end
      if (avs_address == OFS_IEN && be[0]) begin
        s_d.ien = wd[EVT_W-1:0];
      end
    end

    // Winner goes to the core one edge after the flags
    s_d.req = cif.best_valid;
    s_d.lvl = cif.best_valid ? cif.best_level : PRIO_OFF;
    s_d.src = cif.best_valid ? cif.best_idx : '0;

    // Request events seen against the registered request
    evt[EVT_NEW_REQ] = cif.best_valid & ~s_q.req;
    evt[EVT_LVL_UP] = cif.best_valid & s_q.req & (cif.best_level > s_q.lvl);

    // Set beats clear when both arrive together
    s_d.ist = (s_q.ist & ~clr) | evt;
    s_d.irq = |(s_d.ist & s_d.ien);
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= RST_S;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Waitrequest drops in the cycle after the request is seen
  assign avs_waitrequest = acc & (s_q.bus == IEP_IDLE);
  assign avs_readdata = {16'h0000, s_q.rdata};
  assign avs_response = s_q.resp;
  assign cpu_req = s_q.req;
  assign cpu_level = s_q.lvl;
  assign cpu_src = s_q.src;
  assign irq = s_q.irq;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  // Unimplemented enable bits never hold a one
  a_en_unimpl_zero:
    assert property ((s_q.en & ~EN_MASK) == '0)
    else $error("unimplemented enable bit set");

  // Unimplemented priority bits never hold a one
  a_pr_unimpl_zero:
    assert property ((s_q.pr & ~PR_MASK) == '0)
    else $error("unimplemented priority bit set");

  // Untouched enables still read as after reset
  a_reset_enables:
    assert property (!s_q.wr_seen |-> s_q.en == '0)
    else $error("enable not zero before any write");

  // Untouched priority fields still hold level four
  a_reset_prio:
    assert property (!s_q.wr_seen |-> s_q.pr == PR_RST)
    else $error("priority field not at reset value");

  // Nothing enabled anywhere means no request next cycle
  a_blocked_src:
    assert property ((s_q.en == '0 && en_ext == '0) |=> !cpu_req)
    else $error("request with all enables off");

  // A standing request never carries level zero
  a_zero_prio:
    assert property (cpu_req |-> cpu_level != PRIO_OFF)
    else $error("request at disabled level");

  // A level-seven candidate wins on the next edge
  a_top_level:
    assert property (any7 |=> (cpu_req && cpu_level == PRIO_MAX))
    else $error("level seven not reported");

  // Winner is a real candidate at the reported level, then is presented
  a_src_valid:
    assert property (cif.best_valid |-> (cif.valid[cif.best_idx]
                     && cif.level[cif.best_idx] == cif.best_level)
                     ##1 (cpu_src == $past(cif.best_idx)))
    else $error("winner not a valid candidate");

  // Full-width write to the first enable register keeps only its bits
  a_write_en1:
    assert property ((avs_write && !avs_waitrequest && avs_address == OFS_EN_BASE
                      && avs_byteenable[1:0] == 2'h3)
                     |=> s_q.en[0] == ($past(avs_writedata[15:0]) & EN_MASK[0]))
    else $error("enable write not stored");

  // Bus answers after exactly one wait cycle
  a_wait_one:
    assert property ((acc && avs_waitrequest) |=> !avs_waitrequest)
    else $error("waitrequest held too long");

  // New-request status stays until cleared
  a_irq_sticky:
    assert property ((s_q.ist[EVT_NEW_REQ] && !clr[EVT_NEW_REQ]) |=> s_q.ist[EVT_NEW_REQ])
    else $error("status bit dropped without clear");

  // Highest candidate level always wins
  a_best_is_top:
    assert property (cif.best_level == top_lvl)
    else $error("winner below highest candidate level");

  // A request to the core comes from a candidate one edge before
  a_req_from_cand:
    assert property (cpu_req |-> $past(cif.best_valid))
    else $error("request without candidate");

  // An enable-slot winner has its flag and its enable bit set
  a_win_enabled:
    assert property ((cif.best_valid && !cif.best_idx[SRC_W-1])
                     |-> (flag_en_src[cif.best_idx[5:0]]
                          && s_q.en[cif.best_idx[5:4]][cif.best_idx[3:0]]))
    else $error("winner not enabled");

  // No request means level and source both read zero
  a_idle_outputs:
    assert property (!cpu_req |-> (cpu_level == PRIO_OFF && cpu_src == '0))
    else $error("idle request lines not zero");

  // An event in the same cycle as its clear still leaves the bit set
  a_set_wins:
    assert property ((evt != '0) |=> ((s_q.ist & $past(evt)) == $past(evt)))
    else $error("status event lost");

  // Refused accesses answer with the error code, mapped ones with okay
  a_err_response:
    assert property ((acc && avs_waitrequest) |=> (avs_response == ($past(hit) ? RESP_OKAY : RESP_SLVERR)))
    else $error("wrong answer code");

  // A refused write leaves the enable, priority and event enable registers as they were
  a_unmapped_ignored:
    assert property ((avs_write && !avs_waitrequest && !hit)
                     |=> ($stable(s_q.en) && $stable(s_q.pr) && $stable(s_q.ien)))
    else $error("refused write changed a register");

  // Priority registers change only at a committed write
  a_pr_hold:
    assert property (!take_wr |=> $stable(s_q.pr))
    else $error("priority register changed without write");

endmodule

// *** rtl/iep_pkg.sv ***
package iep_pkg;

  // ----------------------------------------------------------------
  // Register map (byte addresses on the 32-bit bus)
  // ----------------------------------------------------------------
  localparam int ADDR_W = 6;
  localparam logic [5:0] OFS_EN_BASE = 6'h00; // Enable registers 1..4, stride 4
  localparam logic [5:0] OFS_PR_BASE = 6'h10; // Priority registers 0..2, stride 4
  localparam logic [5:0] OFS_IST = 6'h1C; // Event status, read only
  localparam logic [5:0] OFS_ICLR = 6'h20; // Event clear, write only
  localparam logic [5:0] OFS_IEN = 6'h24; // Event interrupt enable
  localparam logic [5:0] OFS_CUR = 6'h28; // Current request, read only
  localparam int N_EN_REG = 4;
  localparam int N_PR_REG = 3;

  // ----------------------------------------------------------------
  // Implemented bits and reset values
  // ----------------------------------------------------------------
  // Index 0: uart2 tx/rx, ext_irq2, timer5/4, compare4/3, ext_irq1,
  // pin change, comparator, i2c1 master/slave.
  // Index 1: parallel port, compare5, capture5/4/3, spi2 event/fault.
  // Index 2: calendar, ext_irq4/3, i2c2 master/slave.
  // Index 3: checksum gen, uart2 err, uart1 err.
  localparam logic [3:0][15:0] EN_MASK = {16'h000E, 16'h4066, 16'h22E3, 16'hFE1F};
  localparam logic [3:0][15:0] EN_RST = '0;
  localparam logic [2:0][15:0] PR_MASK = {16'h7777, 16'h7770, 16'h7777};
  // Every priority field comes up as binary 100
  localparam logic [2:0][15:0] PR_RST = {16'h4444, 16'h4440, 16'h4444};

  // ----------------------------------------------------------------
  // Priority levels and sources
  // ----------------------------------------------------------------
  localparam logic [2:0] PRIO_OFF = 3'h0; // Source switched off
  localparam logic [2:0] PRIO_MAX = 3'h7; // Highest level
  localparam int N_EN_SLOT = 64; // One slot per enable-register bit
  localparam int N_PR_SRC = 11; // Sources whose priority lives here
  localparam int N_CAND = 75;
  localparam int SRC_W = 7;

  // ----------------------------------------------------------------
  // Events, bus answers, bus phase
  // ----------------------------------------------------------------
  localparam int EVT_W = 3;
  localparam int EVT_NEW_REQ = 0; // Request to core went high
  localparam int EVT_LVL_UP = 1; // Higher level took over
  localparam int EVT_BUS_ERR = 2; // Unmapped access
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [0:0] {
    IEP_IDLE = 1'h0,
    IEP_ACK = 1'h1
  } iep_bus_e;

  // Byte-lane write into a 16-bit register, unimplemented bits held at zero
  function automatic logic [15:0] iep_merge(input logic [15:0] old, input logic [15:0] wd,
                                            input logic [1:0] be, input logic [15:0] mask);
    logic [15:0] v;
    v = old;
    if (be[0]) v[7:0] = wd[7:0];
    if (be[1]) v[15:8] = wd[15:8];
    return v & mask;
  endfunction

  // Address match for the k-th register of a group
  function automatic logic iep_sel(input logic [5:0] a, input logic [5:0] base, input int k);
    return a == (base + 6'(4 * k));
  endfunction

  // Lowest bit of priority field j within the three registers laid end to end
  function automatic int iep_prio_lsb(input int j);
    int r;
    int s;
    r = (j < 4) ? 0 : ((j < 7) ? 1 : 2);
    s = j - ((r == 0) ? 0 : ((r == 1) ? 4 : 7));
    return r * 16 + 12 - 4 * s;
  endfunction

endpackage

// *** rtl/iep_cand_if.sv ***
`timescale 1ns/1ns
// Candidate requests into the arbiter and its winner back out
interface iep_cand_if import iep_pkg::*; #(parameter int N = N_CAND);
  logic [N-1:0] valid; // Flag, enable and nonzero level all present
  logic [N-1:0][2:0] level; // Level of each candidate
  logic best_valid; // Some candidate present
  logic [2:0] best_level; // Highest level found
  logic [SRC_W-1:0] best_idx; // Its source number

  modport arb (input valid, input level, output best_valid, output best_level,
               output best_idx);
  modport bank (output valid, output level, input best_valid, input best_level,
                input best_idx);
endinterface

// *** rtl/iep_arb.sv ***
`timescale 1ns/1ns
// Picks the highest level; equal levels go to the lowest source number
module iep_arb import iep_pkg::*; #(
  parameter int N = N_CAND
) (
  iep_cand_if.arb c
);

  // ----------------------------------------------------------------
  // Search
  // ----------------------------------------------------------------
  // Walk from the top down so that a lower index wins a tie with >=
  always_comb begin
    logic bv;
    logic [2:0] bl;
    logic [SRC_W-1:0] bi;
    bv = 1'b0;
    bl = PRIO_OFF;
    bi = '0;
    for (int i = N - 1; i >= 0; i--) begin
      if (c.valid[i] && (c.level[i] >= bl)) begin
        bv = 1'b1;
        bl = c.level[i];
        bi = SRC_W'(i);
      end
    end
    c.best_valid = bv;
    c.best_level = bl;
    c.best_idx = bi;
  end

endmodule

// *** testbench/iep_core_model.sv ***
`timescale 1ns/1ns
// ----------------------------------------------------------------
// Core stand-in
// ----------------------------------------------------------------
// Samples the request lines every edge, as the core's vector logic would
module iep_core_model import iep_pkg::*; (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic cpu_req,
  input wire logic [2:0] cpu_level,
  input wire logic [SRC_W-1:0] cpu_src,
  output logic [10:0] seen_q
);
  // One edge of lag, so a glitch that lasts under a cycle never reaches it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 11'h000;
    end else begin
      seen_q <= {cpu_req, cpu_level, cpu_src};
    end
  end
endmodule

// *** testbench/tb_top.sv ***
`timescale 1ns/1ns
module tb_top import iep_pkg::*;;
  // ----------------------------------------------------------------
  // Signals and expected tables
  // ----------------------------------------------------------------
  logic clk, arst_n, avs_read, avs_write, avs_waitrequest, cpu_req, irq;
  logic [ADDR_W-1:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rng;
  logic [3:0] avs_byteenable, lanes; // Lanes: byte enables for the next transfer
  logic [1:0] avs_response;
  logic [N_EN_SLOT-1:0] flag_en_src;
  logic [3*N_EN_SLOT-1:0] prio_ext;
  logic [N_PR_SRC-1:0] flag_pr_src, en_ext;
  logic [2:0] cpu_level;
  logic [SRC_W-1:0] cpu_src;
  logic [10:0] seen;
  logic [17:0] notes[$]; // Pending read answers {response, data}
  int fail_count, checks_done;
  // Implemented enable bits and priority fields, worked out by hand
  localparam logic [63:0] EMASK = {16'h000E, 16'h4066, 16'h22E3, 16'hFE1F};
  localparam logic [47:0] PMASK = {16'h7777, 16'h7770, 16'h7777};
  localparam logic [47:0] PRST = {16'h4444, 16'h4440, 16'h4444};

  iep_bank u_dut (.clk, .arst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .avs_response, .flag_en_src,
    .prio_ext, .flag_pr_src, .en_ext, .cpu_req, .cpu_level, .cpu_src, .irq);
  iep_core_model u_core (.clk, .arst_n, .cpu_req, .cpu_level, .cpu_src, .seen_q(seen));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic chk(input logic [35:0] seen_v, input logic [35:0] exp_v);
    checks_done++;
    if (seen_v !== exp_v) begin
      fail_count++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen_v, exp_v);
    end
  endtask

  // Xorshift source for the random scenarios
  function automatic int rnd(input int m);
    rng ^= rng << 13;
    rng ^= rng >> 17;
    rng ^= rng << 5;
    return int'(rng % m);
  endfunction

  // One Avalon transfer; upper lanes carry junk the block must ignore
  task automatic bus(input logic [5:0] a, input logic wr, input logic [15:0] d,
                     input logic [17:0] e);
    int n;
    n = 0;
    if (!wr) notes.push_back(e);
    avs_address <= a;
    avs_read <= !wr;
    avs_write <= wr;
    avs_writedata <= {rng[15:0], d};
    avs_byteenable <= lanes;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0 && n < 100) begin
      @(posedge clk);
      n++;
    end
    if (n == 100) fail_count++;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk);
  endtask

  task automatic wr(input logic [5:0] a, input logic [15:0] d);
    bus(a, 1'b1, d, 18'h00000);
  endtask

  task automatic rd(input logic [5:0] a, input logic [15:0] e);
    bus(a, 1'b0, 16'h0000, {RESP_OKAY, e});
  endtask

  // Let the request settle, then look at the ports and at the core
  task automatic core(input logic r, input logic [2:0] l, input logic [6:0] s);
    repeat (4) @(posedge clk);
    chk({cpu_req, cpu_level, cpu_src}, {r, l, s});
    chk(seen, {r, l, s});
  endtask

  // Read answers leave the queue oldest first
  always @(posedge clk) begin
    logic [17:0] nv;
    if (avs_read && !avs_waitrequest) begin
      if (notes.size() == 0) begin
        chk(36'h1, 36'h0);
      end else begin
        nv = notes.pop_front();
        chk({avs_response, avs_readdata}, {nv[17:16], 16'h0000, nv[15:0]});
      end
    end
  end

  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // Whole run is a few hundred cycles
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    report_and_stop();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    int s1, s2, l1, l2, r, sft, el, es;
    logic [191:0] p;
    logic [15:0] lv;
    arst_n = 1'b0;
    avs_address = '0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = '0;
    avs_byteenable = '0;
    flag_en_src = '0;
    prio_ext = '0;
    flag_pr_src = '0;
    en_ext = '0;
    rng = 32'h0000923F;
    lanes = 4'hF;
    repeat (16) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    core(1'b0, 3'h0, 7'h00);
    // Reset values, then all ones to find the implemented bits
    for (int k = 0; k < 4; k++) rd(OFS_EN_BASE + 6'(4 * k), 16'h0000);
    for (int k = 0; k < 3; k++) rd(OFS_PR_BASE + 6'(4 * k), PRST[16*k+:16]);
    for (int k = 0; k < 4; k++) begin
      wr(OFS_EN_BASE + 6'(4 * k), 16'hFFFF);
      rd(OFS_EN_BASE + 6'(4 * k), EMASK[16*k+:16]);
    end
    for (int k = 0; k < 3; k++) begin
      wr(OFS_PR_BASE + 6'(4 * k), 16'hFFFF);
      rd(OFS_PR_BASE + 6'(4 * k), PMASK[16*k+:16]);
    end
    // Event interrupt: raise, clear, then a masked bus error
    wr(OFS_ICLR, 16'h0007);
    rd(OFS_IST, 16'h0000);
    wr(OFS_IEN, 16'h0001);
    rd(OFS_IEN, 16'h0001);
    flag_en_src <= 64'h1;
    prio_ext <= 192'h5;
    core(1'b1, 3'h5, 7'h00);
    chk(irq, 1'b1);
    rd(OFS_IST, 16'h0001);
    // A higher level on the standing source counts as a takeover
    prio_ext <= 192'h6;
    core(1'b1, 3'h6, 7'h00);
    rd(OFS_CUR, 16'h0700);
    rd(OFS_IST, 16'h0003);
    rd(OFS_ICLR, 16'h0000);
    wr(OFS_ICLR, 16'h0003);
    repeat (2) @(posedge clk);
    chk(irq, 1'b0);
    bus(6'h01, 1'b0, 16'h0000, {RESP_SLVERR, 16'h0000});
    wr(6'h30, 16'hFFFF);
    rd(OFS_IST, 16'h0004);
    chk(irq, 1'b0);
    // Clearing the enable bit blocks a pending source
    wr(OFS_EN_BASE, 16'h0000);
    core(1'b0, 3'h0, 7'h00);
    wr(OFS_EN_BASE, 16'hFFFF);
    // Only the upper byte lane lands; the lower byte keeps its bits
    lanes = 4'h2;
    wr(OFS_EN_BASE, 16'h0000);
    rd(OFS_EN_BASE, 16'h001F);
    lanes = 4'hF;
    wr(OFS_EN_BASE, 16'hFFFF);
    // Two random slots; ties and level zero come up along the way
    for (int i = 0; i < 24; i++) begin
      s1 = rnd(64);
      s2 = rnd(64);
      l1 = rnd(8);
      l2 = rnd(8);
      if (i % 3 == 0) l2 = l1;
      p = '0;
      p[3*s1+:3] = 3'(l1);
      p[3*s2+:3] = 3'(l2);
      flag_en_src <= (64'h1 << s1) | (64'h1 << s2);
      prio_ext <= p;
      el = 0;
      es = 0;
      for (int s = 0; s < 64; s++) begin
        if ((s == s1 || s == s2) && EMASK[s] && int'(p[3*s+:3]) > el) begin
          el = int'(p[3*s+:3]);
          es = s;
        end
      end
      core(el != 0, 3'(el), 7'(es));
    end
    // Sources whose level comes from the priority registers
    flag_en_src <= '0;
    for (int j = 0; j < 11; j++) begin
      r = (j < 4) ? 0 : ((j < 7) ? 1 : 2);
      sft = 12 - 4 * (j - ((r == 0) ? 0 : ((r == 1) ? 4 : 7)));
      lv = 16'(j % 7 + 1);
      wr(OFS_PR_BASE + 6'(4 * r), lv << sft);
      flag_pr_src <= 11'(1 << j);
      en_ext <= 11'(1 << j);
      core(1'b1, lv[2:0], 7'(64 + j));
      en_ext <= '0;
      core(1'b0, 3'h0, 7'h00);
      wr(OFS_PR_BASE + 6'(4 * r), 16'h0000);
      en_ext <= 11'(1 << j);
      core(1'b0, 3'h0, 7'h00);
    end
    // Reset in mid-run brings back the power-on register values
    arst_n <= 1'b0;
    repeat (2) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    core(1'b1, 3'h4, 7'(64 + 10));
    rd(OFS_EN_BASE, 16'h0000);
    rd(OFS_PR_BASE + 6'h08, PRST[47:32]);
    report_and_stop();
  end
endmodule
